// File: hw/roc_relay_output_conditioner.sv
// Purpose: conditions one relay output: source select, delays, polarity
// Assumes: status inputs come from logic on clk; registers over Avalon-MM
// Notes:   delays are counted in whole milliseconds of a derived tick
//
// Function
// - exactly one status source, or none, drives the relay; fault after reset
// - frequency, current and thermal flags come from threshold compares
// - parameter set one, two or three active are selectable sources
// - per-input live-zero current loop loss warnings are selectable sources
// - a rising information waits the assertion delay, 0 to 60000 ms
// - with the fault source the assertion delay is taken as zero
// - a level setting picks state 1 or state 0 for true information
// - with the fault source the active level is forced to state 1
// - a falling information waits the holding time, 0 to 9999 ms
// - with the fault source the holding time is taken as zero
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
module roc_relay_output_conditioner
	import roc_pkg::*;
#(
	parameter logic [15:0] TICK_CYCLES = 16'(ROC_TICK_CYCLES)
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire roc_avs_req_s avsReq,
	output logic              avsWaitrequest,
	output logic [31:0]       avsReaddata,
	input  wire roc_status_s  driveStatus,
	output logic              relayOut
);

	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [5:0]  srcSel;
		logic [15:0] assertDelay;
		logic [15:0] holdDelay;
		logic        activeLow;
		logic [15:0] freqThd;
		logic [15:0] currThd;
		logic [15:0] thermThd;
		logic        outActive;
		logic        relayOut;
		logic [15:0] msCnt;
		logic [15:0] tickCnt;
		logic        ack;
		logic [31:0] rdata;
	} roc_state_s;

	roc_state_s  cur;
	roc_state_s  next_cur;
	logic        rawInfo;
	logic        isFault;
	logic        pending;
	logic        msTick;
	logic [15:0] delayNow;
	logic        busReq;

	function automatic logic [31:0] mergeBytes(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	function automatic logic [15:0] clampMs(
		input logic [15:0] val,
		input logic [15:0] limit
	);
		return (val > limit) ? limit : val;
	endfunction : clampMs

	////////////////////////////////////////////////////////////////////////
	// source selection
	always_comb begin
		rawInfo = 1'b0;
		case (cur.srcSel)
			ROC_SRC_NONE: begin
				rawInfo = 1'b0;
			end
			ROC_SRC_FAULT: begin
				rawInfo = driveStatus.operatingFault;
			end
			ROC_SRC_RUNNING: begin
				rawInfo = driveStatus.driveRunning;
			end
			ROC_SRC_FREQ: begin
				rawInfo = driveStatus.motorFreq >= cur.freqThd;
			end
			ROC_SRC_CURR: begin
				rawInfo = driveStatus.motorCurrent >= cur.currThd;
			end
			ROC_SRC_THERM: begin
				rawInfo = driveStatus.motorThermal >= cur.thermThd;
			end
			ROC_SRC_FWD: begin
				rawInfo = driveStatus.runForward;
			end
			ROC_SRC_REV: begin
				rawInfo = driveStatus.runReverse;
			end
			ROC_SRC_READY: begin
				rawInfo = driveStatus.ready;
			end
			ROC_SRC_SET1: begin
				rawInfo = driveStatus.paramSet == 2'h1;
			end
			ROC_SRC_SET2: begin
				rawInfo = driveStatus.paramSet == 2'h2;
			end
			ROC_SRC_SET3: begin
				rawInfo = driveStatus.paramSet == 2'h3;
			end
			default: begin
				if (cur.srcSel >= ROC_SRC_LOSS1 &&
				    cur.srcSel < ROC_SRC_LOSS1 + 6'(ROC_NUM_LOSS)) begin
					rawInfo = driveStatus.loopLoss[
						3'(cur.srcSel - ROC_SRC_LOSS1)];
				end else if (cur.srcSel >= ROC_SRC_PUMP1 &&
				    cur.srcSel < ROC_SRC_PUMP1 + 6'(ROC_NUM_PUMP)) begin
					rawInfo = driveStatus.pumpCmd[
						3'(cur.srcSel - ROC_SRC_PUMP1)];
				end else if (cur.srcSel[5:4] == ROC_SRC_GEN0[5:4]) begin
					rawInfo = driveStatus.genStatus[cur.srcSel[3:0]];
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// delay and bus control
	assign isFault        = cur.srcSel == ROC_SRC_FAULT;
	assign pending        = rawInfo != cur.outActive;
	assign msTick         = pending && cur.tickCnt == TICK_CYCLES - 16'h0001;
	assign busReq         = avsReq.read | avsReq.write;
	assign avsWaitrequest = busReq & ~cur.ack;
	assign avsReaddata    = cur.rdata;
	assign relayOut       = cur.relayOut;

	always_comb begin
		next_cur     = cur;
		next_cur.ack = 1'b0;
		if (isFault) begin
			delayNow = 16'h0000;
		end else begin
			delayNow = rawInfo ? cur.assertDelay : cur.holdDelay;
		end
		if (!pending) begin
			next_cur.tickCnt = 16'h0000;
			next_cur.msCnt   = 16'h0000;
		end else if (delayNow == 16'h0000) begin
			next_cur.outActive = rawInfo;
			next_cur.tickCnt   = 16'h0000;
			next_cur.msCnt     = 16'h0000;
		end else if (msTick) begin
			next_cur.tickCnt = 16'h0000;
			if (cur.msCnt + 16'h0001 >= delayNow) begin
				next_cur.outActive = rawInfo;
				next_cur.msCnt     = 16'h0000;
			end else begin
				next_cur.msCnt = cur.msCnt + 16'h0001;
			end
		end else begin
			next_cur.tickCnt = cur.tickCnt + 16'h0001;
		end

		// one wait state per access; read data latched at the first edge
		if (busReq && !cur.ack) begin
			next_cur.ack   = 1'b1;
			next_cur.rdata = 32'h0000_0000;
			if (avsReq.write) begin
				case (avsReq.address)
					ROC_OFS_SOURCE: begin
						next_cur.srcSel = 6'(mergeBytes({26'h0, cur.srcSel},
							avsReq.writedata, avsReq.byteenable));
					end
					// out-of-range delays in bits 15:0 saturate; write bits 31:16 are dropped
					ROC_OFS_ASSERT: begin
						next_cur.assertDelay = clampMs(16'(mergeBytes(
							{16'h0, cur.assertDelay}, avsReq.writedata,
							avsReq.byteenable)), ROC_ASSERT_MAX_MS);
					end
					ROC_OFS_HOLD: begin
						next_cur.holdDelay = clampMs(16'(mergeBytes(
							{16'h0, cur.holdDelay}, avsReq.writedata,
							avsReq.byteenable)), ROC_HOLD_MAX_MS);
					end
					ROC_OFS_LEVEL: begin
						if (avsReq.byteenable[0]) begin
							next_cur.activeLow =
								avsReq.writedata[ROC_LEVEL_LOW_BIT];
						end
					end
					ROC_OFS_FREQ_THD: begin
						next_cur.freqThd = 16'(mergeBytes(32'(cur.freqThd),
							avsReq.writedata, avsReq.byteenable));
					end
					ROC_OFS_CURR_THD: begin
						next_cur.currThd = 16'(mergeBytes(32'(cur.currThd),
							avsReq.writedata, avsReq.byteenable));
					end
					ROC_OFS_THRM_THD: begin
						next_cur.thermThd = 16'(mergeBytes(32'(cur.thermThd),
							avsReq.writedata, avsReq.byteenable));
					end
					default: begin
					end
				endcase
			end else begin
				case (avsReq.address)
					ROC_OFS_SOURCE: begin
						next_cur.rdata[5:0] = cur.srcSel;
					end
					ROC_OFS_ASSERT: begin
						next_cur.rdata[15:0] = cur.assertDelay;
					end
					ROC_OFS_HOLD: begin
						next_cur.rdata[15:0] = cur.holdDelay;
					end
					ROC_OFS_LEVEL: begin
						next_cur.rdata[ROC_LEVEL_LOW_BIT] = cur.activeLow;
					end
					ROC_OFS_FREQ_THD: begin
						next_cur.rdata[15:0] = cur.freqThd;
					end
					ROC_OFS_CURR_THD: begin
						next_cur.rdata[15:0] = cur.currThd;
					end
					ROC_OFS_THRM_THD: begin
						next_cur.rdata[15:0] = cur.thermThd;
					end
					ROC_OFS_STATUS: begin
						next_cur.rdata[ROC_STAT_OUT_BIT]  = cur.relayOut;
						next_cur.rdata[ROC_STAT_INFO_BIT] = rawInfo;
						next_cur.rdata[ROC_STAT_PEND_BIT] = pending;
						next_cur.rdata[ROC_STAT_CNT_LSB +: 16] = cur.msCnt;
					end
					default: begin
					end
				endcase
			end
		end

		next_cur.relayOut = next_cur.outActive ^
			(next_cur.activeLow && next_cur.srcSel != ROC_SRC_FAULT);
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur.srcSel      <= ROC_SRC_FAULT;
			cur.assertDelay <= ROC_RST_DELAY;
			cur.holdDelay   <= ROC_RST_DELAY;
			cur.activeLow   <= ROC_RST_LOW;
			cur.freqThd     <= ROC_RST_THD;
			cur.currThd     <= ROC_RST_THD;
			cur.thermThd    <= ROC_RST_THD;
			cur.outActive   <= 1'b0;
			cur.relayOut    <= 1'b0;
			cur.msCnt       <= 16'h0000;
			cur.tickCnt     <= 16'h0000;
			cur.ack         <= 1'b0;
			cur.rdata       <= 32'h0000_0000;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_route_none: assert property (
		cur.srcSel == ROC_SRC_NONE |-> !rawInfo)
		else $error("unassigned relay sees true information");

	a_freq_thd: assert property (
		cur.srcSel == ROC_SRC_FREQ |->
			rawInfo == (driveStatus.motorFreq >= cur.freqThd))
		else $error("frequency threshold flag wrong");

	a_param_set: assert property (
		cur.srcSel == ROC_SRC_SET2 |->
			rawInfo == (driveStatus.paramSet == 2'h2))
		else $error("parameter set flag wrong");

	a_loop_loss: assert property (
		cur.srcSel == ROC_SRC_LOSS1 |-> rawInfo == driveStatus.loopLoss[0])
		else $error("loop loss flag wrong");

	a_assert_wait: assert property (
		(!isFault && !cur.outActive && rawInfo && cur.msCnt == 16'h0000 &&
		 cur.tickCnt == 16'h0000 && cur.assertDelay != 16'h0000 &&
		 TICK_CYCLES > 16'h0002) |=> !cur.outActive [*2])
		else $error("output asserted before its delay");

	a_fault_nodelay: assert property (
		(isFault && rawInfo && !cur.outActive) |=> cur.outActive)
		else $error("fault source asserted late");

	a_level_low: assert property (
		(!isFault && cur.activeLow && cur.outActive) ##1
		($stable(cur.srcSel) && $stable(cur.activeLow) &&
		 $stable(cur.outActive)) |-> !cur.relayOut)
		else $error("active low choice not honoured");

	a_fault_level: assert property (
		(isFault && cur.outActive) ##1 (isFault && cur.outActive)
		|-> cur.relayOut)
		else $error("fault source not forced to state 1");

	a_hold_zero: assert property (
		(!isFault && cur.holdDelay == 16'h0000 && !rawInfo &&
		 cur.outActive) |=> !cur.outActive)
		else $error("zero holding time not immediate");

	a_fault_nohold: assert property (
		(isFault && !rawInfo && cur.outActive) |=> !cur.outActive)
		else $error("fault source released late");

	a_cancel_delay: assert property (
		(cur.msCnt != 16'h0000 && !pending) |=>
			(cur.msCnt == 16'h0000 && $stable(cur.outActive)))
		else $error("reverted information left delay running");

	a_tick_period: assert property (
		msTick |=> cur.tickCnt == 16'h0000)
		else $error("millisecond tick counter not restarted");

	a_bus_answer: assert property (
		(busReq && avsWaitrequest) |=> (cur.ack && !avsWaitrequest))
		else $error("bus access not answered in one wait state");

	c_fault_assert: cover property (
		isFault && rawInfo && !cur.outActive ##1 cur.relayOut);
	c_delayed_assert: cover property (
		!isFault && msTick && rawInfo ##1 cur.outActive);
	c_delay_cancel: cover property (
		cur.msCnt != 16'h0000 && !pending);
	c_active_low: cover property (
		!isFault && cur.activeLow && cur.outActive && !cur.relayOut);

endmodule : roc_relay_output_conditioner

// File: hw/roc_pkg.sv
// Purpose: shared constants and carriers of the relay output conditioner
// Assumes: 20 MHz system clock, Avalon-MM register slave with 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register
package roc_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and time base
	localparam int unsigned ROC_CLK_HZ        = 20_000_000;
	localparam int unsigned ROC_TICK_US       = 1000;
	localparam int unsigned ROC_TICK_CYCLES   =
		ROC_CLK_HZ / 1_000_000 * ROC_TICK_US;
	localparam logic [15:0] ROC_ASSERT_MAX_MS = 16'hea60;
	localparam logic [15:0] ROC_HOLD_MAX_MS   = 16'h270f;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [4:0] ROC_OFS_SOURCE   = 5'h00;
	localparam logic [4:0] ROC_OFS_ASSERT   = 5'h04;
	localparam logic [4:0] ROC_OFS_HOLD     = 5'h08;
	localparam logic [4:0] ROC_OFS_LEVEL    = 5'h0c;
	localparam logic [4:0] ROC_OFS_FREQ_THD = 5'h10;
	localparam logic [4:0] ROC_OFS_CURR_THD = 5'h14;
	localparam logic [4:0] ROC_OFS_THRM_THD = 5'h18;
	localparam logic [4:0] ROC_OFS_STATUS   = 5'h1c;

	localparam int unsigned ROC_LEVEL_LOW_BIT   = 0;
	localparam int unsigned ROC_STAT_OUT_BIT    = 0;
	localparam int unsigned ROC_STAT_INFO_BIT   = 1;
	localparam int unsigned ROC_STAT_PEND_BIT   = 2;
	localparam int unsigned ROC_STAT_CNT_LSB    = 16;

	localparam logic [15:0] ROC_RST_DELAY = 16'h0000;
	localparam logic [15:0] ROC_RST_THD   = 16'hffff;
	localparam logic        ROC_RST_LOW   = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// source select codes
	localparam logic [5:0] ROC_SRC_NONE    = 6'h00;
	localparam logic [5:0] ROC_SRC_FAULT   = 6'h01;
	localparam logic [5:0] ROC_SRC_RUNNING = 6'h02;
	localparam logic [5:0] ROC_SRC_FREQ    = 6'h03;
	localparam logic [5:0] ROC_SRC_CURR    = 6'h04;
	localparam logic [5:0] ROC_SRC_THERM   = 6'h05;
	localparam logic [5:0] ROC_SRC_FWD     = 6'h06;
	localparam logic [5:0] ROC_SRC_REV     = 6'h07;
	localparam logic [5:0] ROC_SRC_READY   = 6'h08;
	localparam logic [5:0] ROC_SRC_SET1    = 6'h09;
	localparam logic [5:0] ROC_SRC_SET2    = 6'h0a;
	localparam logic [5:0] ROC_SRC_SET3    = 6'h0b;
	localparam logic [5:0] ROC_SRC_LOSS1   = 6'h0c;
	localparam logic [5:0] ROC_SRC_PUMP1   = 6'h11;
	localparam logic [5:0] ROC_SRC_GEN0    = 6'h20;
	localparam int unsigned ROC_NUM_LOSS   = 5;
	localparam int unsigned ROC_NUM_PUMP   = 6;
	localparam int unsigned ROC_NUM_GEN    = 16;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} roc_avs_req_s;

	typedef struct packed {
		logic [15:0] motorFreq;
		logic [15:0] motorCurrent;
		logic [15:0] motorThermal;
		logic [1:0]  paramSet;
		logic [4:0]  loopLoss;
		logic [5:0]  pumpCmd;
		logic        operatingFault;
		logic        driveRunning;
		logic        runForward;
		logic        runReverse;
		logic        ready;
		logic [15:0] genStatus;
	} roc_status_s;

endpackage : roc_pkg

// File: sim/roc_relay_model.sv
// Purpose: behavioural relay coil and contact at the conditioner output
// Assumes: coil driven by relayOut, state 1 energizes the coil
// Notes:   contact only moves after the coil held steady for the settle time
module roc_relay_model
#(
	parameter int SETTLE = 3
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic coil,
	output logic      contact
);
	timeunit 1ns;
	timeprecision 1ps;

	logic lastCoil;
	int   steady;

	////////////////////////////////////////////////////////////////////////
	// a short coil pulse never closes the contact, as with a real armature
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lastCoil <= 1'b0;
			steady   <= 0;
			contact  <= 1'b0;
		end else begin
			lastCoil <= coil;
			if (coil !== lastCoil) begin
				steady <= 0;
			end else if (steady < SETTLE) begin
				steady <= steady + 1;
			end else begin
				contact <= coil;
			end
		end
	end
endmodule : roc_relay_model

// File: sim/tb.sv
// Purpose: self-checking bench of the relay output conditioner
// Assumes: a tick of 4 clocks stands in for one millisecond
// Notes:   waitrequest and read data are sampled at the rising edge
module tb
	import roc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int T = 4;

	logic         clk;
	logic         resetn;
	roc_avs_req_s avsReq;
	logic         avsWaitrequest;
	logic [31:0]  avsReaddata;
	roc_status_s  driveStatus;
	logic         relayOut;
	logic         contact;
	logic [31:0]  q;
	int           n_errors;
	int           checks_done;

	roc_relay_output_conditioner #(.TICK_CYCLES(16'h0004))
	i_roc_relay_output_conditioner (
		.clk            (clk),
		.resetn         (resetn),
		.avsReq         (avsReq),
		.avsWaitrequest (avsWaitrequest),
		.avsReaddata    (avsReaddata),
		.driveStatus    (driveStatus),
		.relayOut       (relayOut)
	);

	roc_relay_model #(.SETTLE(3)) i_roc_relay_model (
		.clk     (clk),
		.resetn  (resetn),
		.coil    (relayOut),
		.contact (contact)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	// slave answer time is not assumed: wait for waitrequest low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge clk);
		avsReq.write      <= wr;
		avsReq.read       <= !wr;
		avsReq.address    <= a;
		avsReq.byteenable <= 4'hf;
		avsReq.writedata  <= d;
		// request stands until waitrequest is seen low at a rising edge;
		// a hang is ended by the watchdog only
		do begin
			@(posedge clk);
		end while (avsWaitrequest !== 1'b0);
		rd = avsReaddata;
		avsReq.read  <= 1'b0;
		avsReq.write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask : wr

	task automatic drv(input roc_status_s v);
		@(posedge clk);
		driveStatus <= v;
	endtask : drv

	task automatic waitc(input int n);
		repeat (n) @(negedge clk);
	endtask : waitc

	function automatic roc_status_s mk(input int c);
		roc_status_s s;
		s = '0;
		case (c)
			2: s.driveRunning = 1'b1;
			3: s.motorFreq = 16'hffff;
			4: s.motorCurrent = 16'hffff;
			5: s.motorThermal = 16'hffff;
			6: s.runForward = 1'b1;
			7: s.runReverse = 1'b1;
			8: s.ready = 1'b1;
			9, 10, 11: s.paramSet = 2'(c - 8);
			default: begin
				if (c >= 12 && c <= 16) s.loopLoss[c - 12] = 1'b1;
				if (c >= 17 && c <= 22) s.pumpCmd[c - 17] = 1'b1;
				if (c >= 32) s.genStatus[c - 32] = 1'b1;
			end
		endcase
		return s;
	endfunction : mk

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(32'(relayOut), 32'h0);
		bus(1'b0, ROC_OFS_SOURCE, 32'h0, q);
		chk(q, 32'h1);
		bus(1'b0, ROC_OFS_ASSERT, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, ROC_OFS_HOLD, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, ROC_OFS_LEVEL, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, ROC_OFS_FREQ_THD, 32'h0, q);
		chk(q, 32'h0000ffff);
		$display("test reset done");
	endtask : t_reset

	task automatic t_fault();
		roc_status_s s;
		s = '0;
		wr(ROC_OFS_ASSERT, 32'h5);
		wr(ROC_OFS_HOLD, 32'h5);
		wr(ROC_OFS_LEVEL, 32'h1);
		s.operatingFault = 1'b1;
		drv(s);
		waitc(3);
		chk(32'(relayOut), 32'h1);
		waitc(6);
		chk(32'(contact), 32'h1);
		drv('0);
		waitc(3);
		chk(32'(relayOut), 32'h0);
		$display("test fault done");
	endtask : t_fault

	task automatic t_delay();
		wr(ROC_OFS_LEVEL, 32'h0);
		wr(ROC_OFS_ASSERT, 32'h3);
		wr(ROC_OFS_HOLD, 32'h2);
		wr(ROC_OFS_SOURCE, 32'(ROC_SRC_READY));
		drv(mk(8));
		waitc(3 * T - 1);
		chk(32'(relayOut), 32'h0);
		waitc(4);
		chk(32'(relayOut), 32'h1);
		drv('0);
		waitc(2 * T - 1);
		chk(32'(relayOut), 32'h1);
		waitc(4);
		chk(32'(relayOut), 32'h0);
		drv(mk(8));
		waitc(6);
		drv('0);
		waitc(16);
		chk(32'(relayOut), 32'h0);
		drv(mk(8));
		waitc(16);
		drv('0);
		waitc(4);
		drv(mk(8));
		waitc(16);
		chk(32'(relayOut), 32'h1);
		$display("test delay done");
	endtask : t_delay

	task automatic t_level();
		wr(ROC_OFS_ASSERT, 32'hffff);
		bus(1'b0, ROC_OFS_ASSERT, 32'h0, q);
		chk(q, 32'(ROC_ASSERT_MAX_MS));
		wr(ROC_OFS_HOLD, 32'hffff);
		bus(1'b0, ROC_OFS_HOLD, 32'h0, q);
		chk(q, 32'(ROC_HOLD_MAX_MS));
		wr(ROC_OFS_ASSERT, 32'h0);
		wr(ROC_OFS_HOLD, 32'h0);
		wr(ROC_OFS_LEVEL, 32'h1);
		waitc(3);
		chk(32'(relayOut), 32'h0);
		drv('0);
		waitc(3);
		chk(32'(relayOut), 32'h1);
		// status is read-only: a write must not disturb the output bit
		wr(ROC_OFS_STATUS, 32'h0);
		bus(1'b0, ROC_OFS_STATUS, 32'h0, q);
		chk(32'(q[ROC_STAT_OUT_BIT]), 32'h1);
		wr(ROC_OFS_LEVEL, 32'h0);
		$display("test level done");
	endtask : t_level

	task automatic t_thd();
		roc_status_s s;
		for (int k = 0; k < 3; k++) begin
			wr(ROC_OFS_SOURCE, 32'(k + 3));
			wr(5'(ROC_OFS_FREQ_THD + 5'(4 * k)), 32'h1000);
			// one below the threshold, then exactly at it
			for (int j = 0; j < 2; j++) begin
				s = '0;
				s.motorFreq    = (k == 0) ? 16'h0fff + 16'(j) : 16'h0;
				s.motorCurrent = (k == 1) ? 16'h0fff + 16'(j) : 16'h0;
				s.motorThermal = (k == 2) ? 16'h0fff + 16'(j) : 16'h0;
				drv(s);
				waitc(3);
				chk(32'(relayOut), 32'(j));
			end
			wr(5'(ROC_OFS_FREQ_THD + 5'(4 * k)), 32'hffff);
		end
		$display("test threshold done");
	endtask : t_thd

	task automatic t_table();
		logic ok;
		for (int c = 0; c < 48; c++) begin
			if (c != 1) begin
				ok = (c != 0) && (c <= 22 || c >= 32);
				wr(ROC_OFS_SOURCE, 32'(c));
				drv(ok ? ~mk(c) : '1);
				waitc(3);
				chk(32'(relayOut), 32'h0);
				drv(mk(c));
				waitc(3);
				chk(32'(relayOut), 32'(ok));
			end
		end
		$display("test table done");
	endtask : t_table

	task automatic t_rst();
		wr(ROC_OFS_ASSERT, 32'h3);
		wr(ROC_OFS_SOURCE, 32'(ROC_SRC_READY));
		drv(mk(8));
		waitc(4 * T);
		chk(32'(relayOut), 32'h1);
		// a second reset in mid-run must restore the source, assertion delay and status defaults
		@(posedge clk);
		resetn <= 1'b0;
		waitc(2);
		chk(32'(relayOut), 32'h0);
		@(posedge clk);
		resetn <= 1'b1;
		bus(1'b0, ROC_OFS_SOURCE, 32'h0, q);
		chk(q, 32'(ROC_SRC_FAULT));
		bus(1'b0, ROC_OFS_ASSERT, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b0, ROC_OFS_STATUS, 32'h0, q);
		chk(q, 32'h0);
		$display("test second reset done");
	endtask : t_rst

	////////////////////////////////////////////////////////////////////////
	initial begin
		n_errors    = 0;
		checks_done = 0;
		resetn      = 1'b0;
		avsReq      = '0;
		driveStatus = '0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		t_reset();
		t_fault();
		t_delay();
		t_level();
		t_thd();
		t_table();
		t_rst();
		summarize();
	end

	// roughly 700 cycles are needed; the limit leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("BAD %0t run did not finish in time", $time);
		summarize();
	end
endmodule : tb
